//--- ddc_cmd_dec.sv
// Command decoder for the DRAM end: pin code to command, with bank-command flag.
// Assumes pins are already sampled on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module ddc_cmd_dec (
    input  wire logic         cs_n,
    input  wire logic         ras_n,
    input  wire logic         cas_n,
    input  wire logic         we_n,
    output ddc_pkg::ddc_cmd_t cmd,
    output logic              is_bank_cmd
);
    import ddc_pkg::*;

    always_comb begin
        cmd = ddc_decode({cs_n, ras_n, cas_n, we_n});
        is_bank_cmd = (cmd == CMD_ACT) || (cmd == CMD_RD) || (cmd == CMD_WR)
                    || (cmd == CMD_PRE);
    end
endmodule // ddc_cmd_dec
`default_nettype wire

//--- ddc_ctrl_end.sv
// Controller end of the command pin link: registers user requests onto pins.
// Assumes the user keeps a request stable until req_ready and clock enable are seen high with it.
`timescale 1ns/1ns
`default_nettype none
module ddc_ctrl_end (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    ddc_if.ctrl                         pins,
    input  wire logic                   req_valid,
    input  wire ddc_pkg::ddc_cmd_t      req_cmd,
    input  wire logic [ddc_pkg::BA_W-1:0]   req_ba,
    input  wire logic [ddc_pkg::ADDR_W-1:0] req_addr,
    input  wire logic                   low_power_req,
    input  wire logic                   odt_req,
    input  wire logic                   dram_reset_req,
    input  wire logic                   wr_beat_valid,
    input  wire logic [ddc_pkg::DQ_W-1:0]   wr_beat_data,
    input  wire logic [1:0]             wr_beat_mask,
    output logic                        req_ready,
    output logic                        req_error
);
    import ddc_pkg::*;

    typedef struct packed {
        logic                 cke;
        logic [3:0]           cmd_pins;
        logic [BA_W-1:0]      ba;
        logic [ADDR_W-1:0]    addr;
        logic                 odt;
        logic                 reset_n;
        logic                 dq_valid;
        logic [DQ_W-1:0]      dq;
        logic [1:0]           mask;
        logic [NBANK-1:0]     open;
        logic [4:0]           hold;
        logic                 ready;
        logic                 error;
    } ddc_ctrl_st_t;

    ddc_ctrl_st_t s_r;
    ddc_ctrl_st_t s_nxt;
    logic         access;
    logic         take;

    ///////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt          = s_r;
        s_nxt.cmd_pins = PIN_DESL;
        s_nxt.error    = 1'b0;
        s_nxt.reset_n  = ~dram_reset_req;
        s_nxt.odt      = odt_req;
        s_nxt.dq_valid = wr_beat_valid;
        s_nxt.dq       = wr_beat_data;
        s_nxt.mask     = wr_beat_mask;
        access = (req_cmd == CMD_RD) || (req_cmd == CMD_WR);
        take   = req_valid && s_r.ready && s_r.cke;

        if (s_r.hold != 5'h0) begin
            s_nxt.hold = s_r.hold - 5'h1;
        end
        // Low power only once no burst is in flight; refresh with it enters self-refresh
        s_nxt.cke = !(low_power_req && s_r.hold == 5'h0
                      && (!take || req_cmd == CMD_REF));

        if (take) begin
            if (access && !s_r.open[req_ba]) begin
                s_nxt.error = 1'b1;
            end else begin
                s_nxt.cmd_pins = ddc_encode(req_cmd);
                s_nxt.ba       = req_ba;
                s_nxt.addr     = req_addr;
                case (req_cmd)
                    CMD_ACT: s_nxt.open[req_ba] = 1'b1;
                    CMD_RD, CMD_WR: begin
                        s_nxt.hold = BURST_HOLD_CYC;
                        s_nxt.cke  = 1'b1;
                        if (req_addr[AP_BIT]) begin
                            s_nxt.open[req_ba] = 1'b0;
                        end
                    end
                    CMD_PRE: begin
                        if (req_addr[AP_BIT]) begin
                            s_nxt.open = BANKS_NONE;
                        end else begin
                            s_nxt.open[req_ba] = 1'b0;
                        end
                    end
                    default: s_nxt.open = s_r.open;
                endcase
            end
        end
        if (dram_reset_req) begin
            s_nxt.open = BANKS_NONE;
        end
        s_nxt.ready = ~dram_reset_req;
    end

    ///////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_r          <= '0;
            s_r.cke      <= 1'b1;
            s_r.cmd_pins <= PIN_DESL;
            s_r.open     <= BANKS_NONE;
            s_r.reset_n  <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pins.cke                   = s_r.cke;
    assign pins.cs_n                  = s_r.cmd_pins[3];
    assign pins.ras_n                 = s_r.cmd_pins[2];
    assign pins.cas_n                 = s_r.cmd_pins[1];
    assign pins.we_n                  = s_r.cmd_pins[0];
    assign pins.ba                    = s_r.ba;
    assign pins.addr                  = s_r.addr;
    assign pins.odt                   = s_r.odt;
    assign pins.reset_n               = s_r.reset_n;
    assign pins.dq_valid              = s_r.dq_valid;
    assign pins.dq                    = s_r.dq;
    assign pins.upper_byte_write_mask = s_r.mask[1];
    assign pins.lower_byte_write_mask = s_r.mask[0];
    assign req_ready                  = s_r.ready;
    assign req_error                  = s_r.error;

endmodule // ddc_ctrl_end
`default_nettype wire

//--- ddc_dram_end.sv
// DRAM end of the command pin link: samples pins, decodes commands, tracks
// power state, open banks, mode registers, termination and write masks.
// Assumes the controller keeps its side: clock enable high through bursts,
// rows opened before access, deselect when idle.
`timescale 1ns/1ns
`default_nettype none
module ddc_dram_end (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    ddc_if.dram                             pins,
    output ddc_pkg::ddc_cmd_t               cmd,
    output logic                            cmd_valid,
    output logic [ddc_pkg::BA_W-1:0]        bank,
    output logic [ddc_pkg::ROW_W-1:0]       row,
    output logic [ddc_pkg::COL_W-1:0]       col,
    output logic                            auto_pre,
    output logic                            pre_all,
    output logic                            burst_chop,
    output logic [ddc_pkg::NBANK-1:0]       open_banks,
    output ddc_pkg::ddc_pwr_t               pwr_state,
    output logic                            term_en,
    output logic                            wr_valid,
    output logic [ddc_pkg::DQ_W-1:0]        wr_data,
    output logic [1:0]                      wr_byte_en,
    output logic                            in_reset
);
    import ddc_pkg::*;

    typedef struct packed {
        ddc_cmd_t                     cmd;
        logic                         cmd_valid;
        logic [BA_W-1:0]              bank;
        logic [ROW_W-1:0]             row;
        logic [COL_W-1:0]             col;
        logic                         auto_pre;
        logic                         pre_all;
        logic                         burst_chop;
        logic [NBANK-1:0]             open;
        ddc_pwr_t                     pwr;
        logic                         term_en;
        logic                         wr_valid;
        logic [DQ_W-1:0]              wr_data;
        logic [1:0]                   wr_byte_en;
        logic                         in_reset;
        logic                         cke_prev;
        logic [MR_NUM-1:0][ADDR_W-1:0] mr;
    } ddc_dram_st_t;

    ddc_dram_st_t s_r;
    ddc_dram_st_t s_nxt;
    ddc_cmd_t     dec_cmd;
    logic         dec_bank_cmd;
    logic         dram_rst;
    logic         term_prog;
    logic         cmd_live;

    ///////////////////////////////////////////////////////////////////////////
    // Decode and reset

    ddc_cmd_dec u_dec (
        .cs_n        (pins.cs_n),
        .ras_n       (pins.ras_n),
        .cas_n       (pins.cas_n),
        .we_n        (pins.we_n),
        .cmd         (dec_cmd),
        .is_bank_cmd (dec_bank_cmd)
    );

    // Either system reset or the device reset pin clears everything
    assign dram_rst = rst | ~pins.reset_n;

    ///////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt = s_r;
        s_nxt.cmd_valid  = 1'b0;
        s_nxt.wr_valid   = 1'b0;
        s_nxt.wr_byte_en = 2'h0;
        s_nxt.in_reset   = 1'b0;
        s_nxt.cke_prev   = pins.cke;
        s_nxt.cmd        = dec_cmd;

        // Termination programmed on in either mode register
        term_prog = s_r.mr[MR_SEL_FIRST][RTT_NOM_B0] | s_r.mr[MR_SEL_FIRST][RTT_NOM_B1]
                  | s_r.mr[MR_SEL_FIRST][RTT_NOM_B2]
                  | (|s_r.mr[MR_SEL_SECOND][RTT_WR_LO +: 2]);

        // Commands only live while running with clock enable high
        cmd_live = (s_r.pwr == PWR_RUN) && pins.cke && (dec_cmd != CMD_DESEL);

        case (s_r.pwr)
            PWR_RUN: begin
                if (s_r.cke_prev && !pins.cke) begin
                    if (dec_cmd == CMD_REF) begin
                        s_nxt.pwr = PWR_SELF;
                    end else if (s_r.open == BANKS_NONE) begin
                        s_nxt.pwr = PWR_PRE_PD;
                    end else begin
                        s_nxt.pwr = PWR_ACT_PD;
                    end
                end
            end
            PWR_PRE_PD, PWR_ACT_PD: begin
                if (pins.cke) begin
                    s_nxt.pwr = PWR_RUN;
                end
            end
            PWR_SELF: begin
                // Only clock enable is listened to; no command needed to leave
                if (pins.cke) begin
                    s_nxt.pwr = PWR_RUN;
                end
            end
            default: begin
                s_nxt.pwr = PWR_RUN;
            end
        endcase

        // Termination: ignored when not programmed or in self-refresh
        if (s_r.pwr == PWR_SELF || !term_prog) begin
            s_nxt.term_en = 1'b0;
        end else begin
            s_nxt.term_en = pins.odt;
        end

        if (cmd_live) begin
            s_nxt.cmd_valid = 1'b1;
            if (dec_bank_cmd) begin
                s_nxt.bank = pins.ba;
            end
            case (dec_cmd)
                CMD_ACT: begin
                    s_nxt.row = pins.addr[ROW_W-1:0];
                    s_nxt.open[pins.ba] = 1'b1;
                end
                CMD_RD, CMD_WR: begin
                    s_nxt.col      = pins.addr[COL_W-1:0];
                    s_nxt.auto_pre = pins.addr[AP_BIT];
                    if (pins.addr[AP_BIT]) begin
                        s_nxt.open[pins.ba] = 1'b0;
                    end
                    case (s_r.mr[MR_SEL_BURST][BL_LO +: 2])
                        BL_OTF:    s_nxt.burst_chop = ~pins.addr[BC_BIT];
                        BL_FIXED4: s_nxt.burst_chop = 1'b1;
                        default:   s_nxt.burst_chop = 1'b0;
                    endcase
                end
                CMD_PRE: begin
                    s_nxt.pre_all = pins.addr[AP_BIT];
                    if (pins.addr[AP_BIT]) begin
                        s_nxt.open = BANKS_NONE;
                    end else begin
                        s_nxt.open[pins.ba] = 1'b0;
                    end
                end
                CMD_MRS: begin
                    // Top bank bit must be clear for a valid register select
                    if (!pins.ba[BA_W-1]) begin
                        s_nxt.mr[pins.ba[MR_W-1:0]] = pins.addr;
                    end
                    s_nxt.bank = pins.ba;
                end
                default: begin
                    s_nxt.bank = s_r.bank;
                end
            endcase
        end

        // Each sampled beat stands for one data strobe edge
        if (pins.dq_valid && s_r.pwr == PWR_RUN && pins.cke) begin
            s_nxt.wr_valid   = 1'b1;
            s_nxt.wr_data    = pins.dq;
            s_nxt.wr_byte_en = {~pins.upper_byte_write_mask,
                                ~pins.lower_byte_write_mask};
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge sys_clk or posedge dram_rst) begin
        if (dram_rst) begin
            s_r            <= '0;
            s_r.cmd        <= CMD_DESEL;
            s_r.pwr        <= PWR_RUN;
            s_r.open       <= BANKS_NONE;
            s_r.in_reset   <= 1'b1;
            s_r.cke_prev   <= 1'b1;
            s_r.mr         <= {MR_NUM{MR_RESET_VAL}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cmd        = s_r.cmd;
    assign cmd_valid  = s_r.cmd_valid;
    assign bank       = s_r.bank;
    assign row        = s_r.row;
    assign col        = s_r.col;
    assign auto_pre   = s_r.auto_pre;
    assign pre_all    = s_r.pre_all;
    assign burst_chop = s_r.burst_chop;
    assign open_banks = s_r.open;
    assign pwr_state  = s_r.pwr;
    assign term_en    = s_r.term_en;
    assign wr_valid   = s_r.wr_valid;
    assign wr_data    = s_r.wr_data;
    assign wr_byte_en = s_r.wr_byte_en;
    assign in_reset   = s_r.in_reset;

endmodule // ddc_dram_end
`default_nettype wire

//--- ddc_if.sv
// Command, address, control and write-data pins between controller and DRAM.
// Assumes the testbench supplies sys_clk to both ends separately.
`timescale 1ns/1ns
`default_nettype none
interface ddc_if;
    import ddc_pkg::*;
    logic                 cke;
    logic                 cs_n;
    logic                 ras_n;
    logic                 cas_n;
    logic                 we_n;
    logic [BA_W-1:0]      ba;
    logic [ADDR_W-1:0]    addr;
    logic                 odt;
    logic                 reset_n;
    logic                 dq_valid;
    logic [DQ_W-1:0]      dq;
    logic                 upper_byte_write_mask;
    logic                 lower_byte_write_mask;

    modport ctrl (
        output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, reset_n,
        output dq_valid, dq, upper_byte_write_mask, lower_byte_write_mask
    );
    modport dram (
        input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, reset_n,
        input dq_valid, dq, upper_byte_write_mask, lower_byte_write_mask
    );
endinterface
`default_nettype wire

//--- ddc_link_chk.sv
// Checker for the command pins between controller end and DRAM end.
// Assumes instantiation beside the link interface, one clock, rst high.
`timescale 1ns/1ns
`default_nettype none
module ddc_link_chk (
    input wire logic                         sys_clk,
    input wire logic                         rst,
    input wire logic                         cke,
    input wire logic                         cs_n,
    input wire logic                         ras_n,
    input wire logic                         cas_n,
    input wire logic                         we_n,
    input wire logic [ddc_pkg::BA_W-1:0]     ba,
    input wire logic [ddc_pkg::ADDR_W-1:0]   addr,
    input wire logic                         reset_n
);
    import ddc_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    logic [3:0]       pins_w;
    logic             acc_w;
    logic [4:0]       hold_r;
    logic [NBANK-1:0] open_r;
    assign pins_w = {cs_n, ras_n, cas_n, we_n};
    assign acc_w  = (pins_w == PIN_RD) || (pins_w == PIN_WR);
    // Banks the pins have opened and not since closed
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hold_r <= 5'h00;
            open_r <= BANKS_NONE;
        end else begin
            hold_r <= acc_w ? 5'h0f : (hold_r != 5'h00 ? hold_r - 5'h01 : 5'h00);
            if (pins_w == PIN_ACT) begin
                open_r[ba] <= 1'b1;
            end else if (pins_w == PIN_PRE && addr[AP_BIT]) begin
                open_r <= BANKS_NONE;
            end else if ((pins_w == PIN_PRE) || (acc_w && addr[AP_BIT])) begin
                open_r[ba] <= 1'b0;
            end
            // Device reset forgets every open row
            if (!reset_n) begin
                open_r <= BANKS_NONE;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_live;
        !cs_n;
    endsequence
    sequence s_access;
        acc_w;
    endsequence
    cmd_single_cycle_a: assert property (s_live |=> cs_n)
        else $error("command held past one cycle");
    desel_code_a: assert property (cs_n |-> ras_n && cas_n && we_n)
        else $error("deselect with strobes active");
    cke_burst_hold_a: assert property (hold_r != 5'h00 |-> cke)
        else $error("clock enable low during burst");
    row_open_first_a: assert property (s_access |-> open_r[ba])
        else $error("access to closed bank");
    lowpow_quiet_a: assert property (!cke && !$past(cke) |-> cs_n)
        else $error("command in power-down");
    cke_exit_plain_a: assert property ($rose(cke) |-> cs_n)
        else $error("command on power-down exit");
    reset_quiet_a: assert property (!reset_n && !$past(reset_n) |-> cs_n)
        else $error("command during device reset");
    reset_rise_a: assert property ($rose(reset_n) |-> cs_n ##1 cs_n)
        else $error("command at reset release");
endmodule // ddc_link_chk
`default_nettype wire

//--- ddc_pkg.sv
// Shared constants, types and decode helpers for the DRAM command pin link.
// Assumes both ends run on one sys_clk; command pins change only on its edge.
package ddc_pkg;

    localparam int BA_W    = 3;
    localparam int ADDR_W  = 13;
    localparam int ROW_W   = 13;
    localparam int COL_W   = 10;
    localparam int NBANK   = 8;
    localparam int DQ_W    = 16;
    localparam int BYTE_W  = 8;
    localparam int MR_NUM  = 4;
    localparam int MR_W    = 2;

    // Address bits with a second meaning
    localparam int AP_BIT  = 10;
    localparam int BC_BIT  = 12;

    // Burst field of the burst-setup mode register
    localparam int          BL_LO       = 0;
    localparam logic [1:0]  BL_FIXED8   = 2'h0;
    localparam logic [1:0]  BL_OTF      = 2'h1;
    localparam logic [1:0]  BL_FIXED4   = 2'h2;

    // Termination fields in first and second mode registers
    localparam int RTT_NOM_B0 = 2;
    localparam int RTT_NOM_B1 = 6;
    localparam int RTT_NOM_B2 = 9;
    localparam int RTT_WR_LO  = 9;

    localparam logic [MR_W-1:0] MR_SEL_BURST  = 2'h0;
    localparam logic [MR_W-1:0] MR_SEL_FIRST  = 2'h1;
    localparam logic [MR_W-1:0] MR_SEL_SECOND = 2'h2;

    localparam logic [ADDR_W-1:0] MR_RESET_VAL = 13'h0000;
    localparam logic [NBANK-1:0]  BANKS_NONE   = 8'h00;
    localparam logic [NBANK-1:0]  BANKS_ALL    = 8'hff;

    // Clock-enable hold after a read or write: latency plus full burst
    localparam logic [4:0] BURST_HOLD_CYC = 5'h10;

    // Pin codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] PIN_MRS  = 4'h0;
    localparam logic [3:0] PIN_REF  = 4'h1;
    localparam logic [3:0] PIN_PRE  = 4'h2;
    localparam logic [3:0] PIN_ACT  = 4'h3;
    localparam logic [3:0] PIN_WR   = 4'h4;
    localparam logic [3:0] PIN_RD   = 4'h5;
    localparam logic [3:0] PIN_ZQ   = 4'h6;
    localparam logic [3:0] PIN_NOP  = 4'h7;
    localparam logic [3:0] PIN_DESL = 4'hf;

    typedef enum logic [3:0] {
        CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR,
        CMD_PRE, CMD_REF, CMD_MRS, CMD_ZQ
    } ddc_cmd_t;

    typedef enum logic [1:0] {
        PWR_RUN, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF
    } ddc_pwr_t;

    function automatic ddc_cmd_t ddc_decode(input logic [3:0] pins);
        ddc_cmd_t c;
        c = CMD_NOP;
        if (pins[3]) begin
            c = CMD_DESEL;
        end else begin
            case (pins)
                PIN_MRS: c = CMD_MRS;
                PIN_REF: c = CMD_REF;
                PIN_PRE: c = CMD_PRE;
                PIN_ACT: c = CMD_ACT;
                PIN_WR:  c = CMD_WR;
                PIN_RD:  c = CMD_RD;
                PIN_ZQ:  c = CMD_ZQ;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction

    function automatic logic [3:0] ddc_encode(input ddc_cmd_t c);
        logic [3:0] p;
        p = PIN_DESL;
        case (c)
            CMD_MRS: p = PIN_MRS;
            CMD_REF: p = PIN_REF;
            CMD_PRE: p = PIN_PRE;
            CMD_ACT: p = PIN_ACT;
            CMD_WR:  p = PIN_WR;
            CMD_RD:  p = PIN_RD;
            CMD_ZQ:  p = PIN_ZQ;
            CMD_NOP: p = PIN_NOP;
            default: p = PIN_DESL;
        endcase
        return p;
    endfunction

endpackage

//--- test_dram_command_pin_interface.sv
// Testbench: controller end and DRAM end joined by the link interface.
// Assumes design files and the link checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_dram_command_pin_interface;
    import ddc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0, low_power_req = 1'b0, odt_req = 1'b0;
    logic dram_reset_req = 1'b0, wr_beat_valid = 1'b0;
    ddc_cmd_t req_cmd = CMD_NOP;
    logic [2:0] req_ba = 3'h0;
    logic [12:0] req_addr = 13'h0000;
    logic [15:0] wr_beat_data = 16'h0000;
    logic [1:0] wr_beat_mask = 2'h0;
    ddc_cmd_t cmd;
    ddc_pwr_t pwr_state;
    logic cmd_valid, auto_pre, pre_all, burst_chop, term_en, wr_valid, in_reset;
    logic req_ready, req_error, err_seen;
    logic [2:0] bank;
    logic [12:0] row;
    logic [9:0] col;
    logic [7:0] open_banks;
    logic [15:0] wr_data;
    logic [1:0] wr_byte_en;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc_n = 0;
    ddc_if link();
    ddc_ctrl_end u_ddc_ctrl_end (.sys_clk, .rst, .pins(link), .req_valid, .req_cmd, .req_ba,
        .req_addr, .low_power_req, .odt_req, .dram_reset_req, .wr_beat_valid,
        .wr_beat_data, .wr_beat_mask, .req_ready, .req_error);
    ddc_dram_end u_ddc_dram_end (.sys_clk, .rst, .pins(link), .cmd, .cmd_valid, .bank, .row,
        .col, .auto_pre, .pre_all, .burst_chop, .open_banks, .pwr_state, .term_en,
        .wr_valid, .wr_data, .wr_byte_en, .in_reset);
    ddc_link_chk u_ddc_link_chk (.sys_clk, .rst, .cke(link.cke), .cs_n(link.cs_n),
        .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba),
        .addr(link.addr), .reset_n(link.reset_n));
    always #2 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task test_done;
        if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            n_errors++;
            test_done;
        end
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Request held until taken; returns once the DRAM end has sampled it
    task issue(input ddc_cmd_t c, input logic [2:0] b, input logic [12:0] a);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_cmd = c;
        req_ba = b;
        req_addr = a;
        while ((req_ready !== 1'b1 || link.cke !== 1'b1) && n < 50) begin
            n++;
            cyc(1);
        end
        if (n == 50) n_errors++;
        @(posedge sys_clk);
        #1 req_valid = 1'b0;
        err_seen = req_error;
        cyc(1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_act_write;
        issue(CMD_ACT, 3'h5, 13'h1abc);
        chk(cmd_valid, 1'b1);
        chk(bank, 3'h5);
        chk(row, 13'h1abc);
        chk(open_banks, 8'h20);
        issue(CMD_WR, 3'h5, 13'h1155);
        chk(cmd, CMD_WR);
        chk(col, 10'h155);
        chk(auto_pre, 1'b0);
        chk(burst_chop, 1'b0);
        wr_beat_valid = 1'b1;
        wr_beat_data = 16'ha55a;
        wr_beat_mask = 2'b10;
        cyc(1);
        wr_beat_valid = 1'b0;
        cyc(1);
        chk(wr_valid, 1'b1);
        chk(wr_data, 16'ha55a);
        chk(wr_byte_en, 2'b01);
    endtask
    task t_chop;
        issue(CMD_RD, 3'h5, 13'h0003);
        chk(burst_chop, 1'b0);
        issue(CMD_MRS, 3'h0, {11'h000, BL_OTF});
        issue(CMD_RD, 3'h5, 13'h0407);
        chk(burst_chop, 1'b1);
        chk(auto_pre, 1'b1);
        chk(open_banks, 8'h00);
        issue(CMD_RD, 3'h3, 13'h0000);
        chk(err_seen, 1'b1);
        chk(cmd_valid, 1'b0);
    endtask
    task t_pre;
        issue(CMD_ACT, 3'h1, 13'h0010);
        issue(CMD_ACT, 3'h2, 13'h0020);
        chk(open_banks, 8'h06);
        issue(CMD_PRE, 3'h1, 13'h0000);
        chk(open_banks, 8'h04);
        chk(pre_all, 1'b0);
        issue(CMD_ACT, 3'h1, 13'h0010);
        issue(CMD_PRE, 3'h1, 13'h0400);
        chk(open_banks, 8'h00);
        chk(pre_all, 1'b1);
    endtask
    task t_odt;
        odt_req = 1'b1;
        cyc(3);
        chk(term_en, 1'b0);
        issue(CMD_MRS, 3'h1, 13'h0004);
        cyc(2);
        chk(term_en, 1'b1);
        low_power_req = 1'b1;
        issue(CMD_REF, 3'h0, 13'h0000);
        cyc(1);
        chk(pwr_state, PWR_SELF);
        chk(term_en, 1'b0);
        low_power_req = 1'b0;
        cyc(3);
        chk(pwr_state, PWR_RUN);
        chk(term_en, 1'b1);
        odt_req = 1'b0;
        cyc(3);
        chk(term_en, 1'b0);
    endtask
    task lp(input ddc_pwr_t exp);
        low_power_req = 1'b1;
        cyc(24);
        chk(pwr_state, exp);
        low_power_req = 1'b0;
        cyc(4);
        chk(pwr_state, PWR_RUN);
    endtask
    task t_reset;
        issue(CMD_ACT, 3'h7, 13'h0001);
        lp(PWR_ACT_PD);
        dram_reset_req = 1'b1;
        cyc(3);
        chk(in_reset, 1'b1);
        chk(req_ready, 1'b0);
        chk(open_banks, 8'h00);
        chk(cmd, CMD_DESEL);
        dram_reset_req = 1'b0;
        cyc(4);
        chk(in_reset, 1'b0);
        lp(PWR_PRE_PD);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(4);
        rst = 1'b0;
        cyc(2);
        t_act_write;
        t_chop;
        t_pre;
        t_odt;
        t_reset;
        test_done;
    end
endmodule // test_dram_command_pin_interface
`default_nettype wire
